// ### include/sscp_pkg.sv
// Purpose: Shared constants, types and helpers for the serial slave command port.
// Assumes: A 100 MHz system clock samples the two-wire bus pins.
// Notes on behaviour
// - Send byte: address+write, command, stop.
// - Completed send byte clears recorded faults.
// - Repeated start after command allows read.
// - Write byte: address, command, data, all acknowledged.
// - Write word: address, command, two data bytes.
// - Block write: command, count N, N bytes; the port takes no count, every byte after the command is data.
// - Acknowledge every byte of a block write.
// - Read byte: repeated start, read address, one byte.
// - Read word returns low byte, then high.
// - Block read sends count then N bytes; the port sends no count, only register bytes from the pointer on.
// - Enabled bus idle for 35 ms releases bus.
// - Config bit 3 enables timeout, reset disabled.
// - Acknowledge only our own 7-bit address.
// - Pointer must be written in same sequence.
// - Direction fixed per start or repeated start.
`default_nettype none

package sscp_pkg;

  // Command code of the port configuration register.
  localparam logic [7:0] SSCP_CFG_ADDR = 8'hD1;
  // Bit position of the timeout enable in the configuration register.
  localparam int SSCP_TO_EN_BIT = 3;
  // Configuration value after reset: timeout disabled.
  localparam logic [7:0] SSCP_CFG_RESET = 8'h00;
  // Value returned when no valid pointer has been written this sequence.
  localparam logic [7:0] SSCP_NO_PTR_DATA = 8'hFF;
  // Pointer value after reset.
  localparam logic [7:0] SSCP_PTR_RESET = 8'h00;
  // Bits in one byte on the wire.
  localparam logic [3:0] SSCP_BYTE_BITS = 4'h8;
  // System clock rate in kHz, and the bus timeout in ms.
  localparam int SSCP_CLK_KHZ = 100000;
  localparam int SSCP_TIMEOUT_MS = 35;
  // Timeout in clock cycles; a longest time, exact here.
  localparam int SSCP_TIMEOUT_CYC = SSCP_TIMEOUT_MS * SSCP_CLK_KHZ;
  // Width of the inactivity counter, enough for the timeout count.
  localparam int SSCP_TO_W = 22;
  // Own 7-bit address default; the value is arbitrary.
  localparam logic [6:0] SSCP_OWN_ADDR = 7'h2C;

  // One-hot states of the transaction machine.
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX       = 7'h08,
    ST_RX_ACK   = 7'h10,
    ST_TX       = 7'h20,
    ST_TX_ACK   = 7'h40
  } sscp_state_t;

  // Register pointer advance, used after every written data byte and every sent byte.
  function automatic logic [7:0] sscp_inc(input logic [7:0] ptr);
    sscp_inc = ptr + 8'h01;
  endfunction : sscp_inc

endpackage : sscp_pkg

`default_nettype wire

// ### verilog/sscp_regmem.sv
// Purpose: Byte-wide command register store behind the serial port.
// Assumes: One write and one read port on the system clock.
// Notes: Read data come out of a register, one cycle after the address.
`default_nettype none

module sscp_regmem
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data_ff
);
  import sscp_pkg::*;

  // The storage itself; not reset, so software must write before trusting it.
  logic [7:0] mem_ff [0:255];

  // Write port.
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // Registered read port.
  always_ff @(posedge clk)
  begin
    rd_data_ff <= mem_ff[rd_addr];
  end

endmodule : sscp_regmem

`default_nettype wire

// ### verilog/sscp_port.sv
// Purpose: Two-wire serial slave port giving a bus master access to command registers.
// Assumes: Bus clock and data pins are asynchronous and far slower than clk.
// Notes: Sequential pointer addressing serves byte, word and block transfers alike.
`default_nettype none

module sscp_port
#(
  parameter logic [6:0] SLAVE_ADDR = sscp_pkg::SSCP_OWN_ADDR,
  parameter int TIMEOUT_CYCLES = sscp_pkg::SSCP_TIMEOUT_CYC
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic clear_faults,
  output logic bus_timeout,
  output logic idle_timeout_enable
);
  import sscp_pkg::*;

  // Two-stage synchronisers for both pins, plus one delayed copy for edges.
  logic scl_s1_ff;
  logic scl_s2_ff;
  logic scl_d_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic sda_d_ff;

  // Transaction state.
  sscp_state_t state_ff;
  sscp_state_t nxt_state;
  logic [3:0] cnt_ff; // Bits shifted in the current byte.
  logic [3:0] nxt_cnt;
  logic [7:0] sh_ff; // Shift register for both directions.
  logic [7:0] nxt_sh;
  logic rw_ff; // Direction bit of the current addressing.
  logic nxt_rw;
  logic first_ff; // Next written byte is the command code.
  logic nxt_first;
  logic [7:0] ptr_ff; // Register pointer.
  logic [7:0] nxt_ptr;
  logic ptr_valid_ff; // Pointer written in this access sequence.
  logic nxt_ptr_valid;
  logic cmd_only_ff; // Only a command code was written so far.
  logic nxt_cmd_only;
  logic oe_ff; // High while pulling the data line low.
  logic nxt_oe;
  logic nack_ff; // Master answered the last sent byte with no-acknowledge.
  logic nxt_nack;
  logic [7:0] cfg_ff; // Port configuration register.
  logic [7:0] nxt_cfg;
  logic clr_ff; // Clear-faults pulse.
  logic nxt_clr;
  logic to_pulse_ff; // Timeout event pulse.
  logic nxt_to_pulse;
  logic [SSCP_TO_W-1:0] to_cnt_ff; // Bus inactivity counter.
  logic [SSCP_TO_W-1:0] nxt_to_cnt;

  // Memory port signals.
  logic mem_we;
  logic [7:0] mem_rd;

  // Bus events decoded from the synchronised pins.
  wire scl_rise = scl_s2_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s2_ff & scl_d_ff;
  wire start_det = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  wire stop_det = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
  wire bus_activity = (scl_s2_ff != scl_d_ff) | (sda_s2_ff != sda_d_ff);
  wire byte_done = (cnt_ff == SSCP_BYTE_BITS);
  wire addr_match = (sh_ff[7:1] == SLAVE_ADDR);
  wire ptr_is_cfg = (ptr_ff == SSCP_CFG_ADDR);
  wire idle_timeout_off = ~cfg_ff[SSCP_TO_EN_BIT];

  // Data returned to the master: blocked until the pointer has been written.
  wire [7:0] rd_byte = !ptr_valid_ff ? SSCP_NO_PTR_DATA :
                       ptr_is_cfg ? cfg_ff : mem_rd;

  // The timeout only matters while a transaction holds the machine busy.
  wire timeout_hit = !idle_timeout_off && (state_ff != ST_IDLE) &&
                     (to_cnt_ff == SSCP_TO_W'(TIMEOUT_CYCLES - 1));

  // Register store for all command codes except the configuration register.
  sscp_regmem u_regmem
  (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(ptr_ff),
    .wr_data(sh_ff),
    .rd_addr(ptr_ff),
    .rd_data_ff(mem_rd)
  );

  // Open-drain style: the line is only ever pulled low, never driven high.
  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;
  assign clear_faults = clr_ff;
  assign bus_timeout = to_pulse_ff;
  assign idle_timeout_enable = cfg_ff[SSCP_TO_EN_BIT];

  // Inactivity counter; any pin change restarts it.
  always_comb
  begin
    if (bus_activity || state_ff == ST_IDLE || idle_timeout_off || timeout_hit)
    begin
      nxt_to_cnt = '0;
    end
    else
    begin
      nxt_to_cnt = to_cnt_ff + SSCP_TO_W'(1);
    end
  end

  // Transaction machine. Bytes are shifted in on the rising clock edge and
  // the data line only changes after a falling edge or on a timeout, so short
  // of a timeout it is stable while the clock is high and is never mistaken for a start or stop.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_rw = rw_ff;
    nxt_first = first_ff;
    nxt_ptr = ptr_ff;
    nxt_ptr_valid = ptr_valid_ff;
    nxt_cmd_only = cmd_only_ff;
    nxt_oe = oe_ff;
    nxt_nack = nack_ff;
    nxt_cfg = cfg_ff;
    nxt_clr = 1'b0;
    nxt_to_pulse = 1'b0;
    mem_we = 1'b0;
    if (timeout_hit)
    begin
      // A stuck bus: let go of the line and wait for a fresh start.
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
      nxt_ptr_valid = 1'b0;
      nxt_cmd_only = 1'b0;
      nxt_to_pulse = 1'b1;
    end
    else if (start_det)
    begin
      // A start or repeated start; the pointer survives a repeated start.
      nxt_state = ST_ADDR;
      nxt_cnt = '0;
      nxt_oe = 1'b0;
      nxt_cmd_only = 1'b0;
    end
    else if (stop_det)
    begin
      // A write that carried only a command code is the clear-faults request.
      // The stop's own clock rise has already shifted one bit in, so a count
      // of one still means that no data byte was begun.
      nxt_clr = cmd_only_ff && (state_ff == ST_RX) && (cnt_ff <= 4'h1);
      nxt_state = ST_IDLE;
      nxt_oe = 1'b0;
      nxt_ptr_valid = 1'b0;
      nxt_cmd_only = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_ADDR, ST_RX:
        begin
          if (scl_rise && !byte_done)
          begin
            // Most significant bit first.
            nxt_sh = {sh_ff[6:0], sda_s2_ff};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall && byte_done && state_ff == ST_ADDR)
          begin
            if (addr_match)
            begin
              // Our address: acknowledge and latch the direction.
              nxt_oe = 1'b1;
              nxt_rw = sh_ff[0];
              nxt_state = ST_ADDR_ACK;
            end
            else
            begin
              // Someone else's address: stay off the line until the next start.
              nxt_state = ST_IDLE;
            end
          end
          else if (scl_fall && byte_done)
          begin
            // Every received byte is acknowledged, however many there are.
            nxt_oe = 1'b1;
            nxt_state = ST_RX_ACK;
            if (first_ff)
            begin
              // The first byte is always the pointer.
              nxt_ptr = sh_ff;
              nxt_ptr_valid = 1'b1;
              nxt_cmd_only = 1'b1;
              nxt_first = 1'b0;
            end
            else
            begin
              // Data byte: store it and move to the next register.
              if (ptr_is_cfg)
              begin
                nxt_cfg = sh_ff;
              end
              mem_we = !ptr_is_cfg;
              nxt_ptr = sscp_inc(ptr_ff);
              nxt_cmd_only = 1'b0;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall && rw_ff)
          begin
            // Read: the first byte goes out with the acknowledge's clock low.
            nxt_oe = ~rd_byte[7];
            nxt_sh = {rd_byte[6:0], 1'b0};
            nxt_cnt = 4'h1;
            nxt_state = ST_TX;
          end
          else if (scl_fall)
          begin
            nxt_oe = 1'b0;
            nxt_cnt = '0;
            nxt_first = 1'b1;
            nxt_state = ST_RX;
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            nxt_oe = 1'b0;
            nxt_cnt = '0;
            nxt_state = ST_RX;
          end
        end
        ST_TX:
        begin
          if (scl_fall && byte_done)
          begin
            // Byte sent: free the line for the master's answer.
            nxt_oe = 1'b0;
            nxt_ptr = sscp_inc(ptr_ff);
            nxt_state = ST_TX_ACK;
          end
          else if (scl_fall)
          begin
            nxt_oe = ~sh_ff[7];
            nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            nxt_nack = sda_s2_ff;
          end
          else if (scl_fall && nack_ff)
          begin
            // No-acknowledge ends the read; wait for stop or a new start.
            nxt_state = ST_IDLE;
          end
          else if (scl_fall)
          begin
            // Acknowledge asks for the next register, low byte before high.
            nxt_oe = ~rd_byte[7];
            nxt_sh = {rd_byte[6:0], 1'b0};
            nxt_cnt = 4'h1;
            nxt_state = ST_TX;
          end
        end
        default:
        begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // Pin synchronisers: the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
    end
  end

  // Control registers of the transaction machine.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      sh_ff <= '0;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      ptr_ff <= SSCP_PTR_RESET;
      ptr_valid_ff <= 1'b0;
      cmd_only_ff <= 1'b0;
      oe_ff <= 1'b0;
      nack_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rw_ff <= nxt_rw;
      first_ff <= nxt_first;
      ptr_ff <= nxt_ptr;
      ptr_valid_ff <= nxt_ptr_valid;
      cmd_only_ff <= nxt_cmd_only;
      oe_ff <= nxt_oe;
      nack_ff <= nxt_nack;
    end
  end

  // Configuration, event pulses and the inactivity counter.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_ff <= SSCP_CFG_RESET;
      clr_ff <= 1'b0;
      to_pulse_ff <= 1'b0;
      to_cnt_ff <= '0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      clr_ff <= nxt_clr;
      to_pulse_ff <= nxt_to_pulse;
      to_cnt_ff <= nxt_to_cnt;
    end
  end

endmodule : sscp_port

`default_nettype wire

// ### tb/sscp_port_asserts.sv
// Purpose: Pin timing checks for the serial command port.
// Assumes: Sees the port's own pins only, all on clk.
// Notes: Helpers use raw pins, so figures allow for synchroniser lag.
`default_nettype none

module sscp_port_asserts
#(
  parameter int TIMEOUT_CYCLES = 200
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic clear_faults,
  input wire logic bus_timeout,
  input wire logic idle_timeout_enable
);
  // Last pin levels, and cycles since a clock fall, a stop and any pin move.
  logic scl_ff;
  logic sda_ff;
  logic [3:0] fall_ff;
  logic [3:0] stop_ff;
  int quiet_ff;
  wire logic fall = scl_ff & ~scl_in;
  wire logic bus_stop = scl_ff & scl_in & ~sda_ff & sda_in;
  wire logic move = (scl_ff ^ scl_in) | (sda_ff ^ sda_in);
  // Saturate at 15 so a long idle spell never wraps back into range.
  wire logic [3:0] nxt_fall = fall ? 4'h1 : fall_ff + {3'h0, fall_ff != 4'hF};
  wire logic [3:0] nxt_stop = bus_stop ? 4'h1 : stop_ff + {3'h0, stop_ff != 4'hF};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Helper registers start from an idle bus.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      fall_ff <= 4'hF;
      stop_ff <= 4'hF;
      quiet_ff <= 0;
    end
    else
    begin
      scl_ff <= scl_in;
      sda_ff <= sda_in;
      fall_ff <= nxt_fall;
      stop_ff <= nxt_stop;
      quiet_ff <= move ? 0 : quiet_ff + 1;
    end
  end
  a_line_low_only: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_cf_one_cycle: assert property (clear_faults |=> !clear_faults)
    else $error("clear pulse too long");
  a_cf_after_stop: assert property (clear_faults |-> stop_ff inside {[4'h1:4'h8]})
    else $error("clear pulse without stop");
  a_to_one_cycle: assert property (bus_timeout |=> !bus_timeout)
    else $error("timeout pulse too long");
  a_to_enabled: assert property (bus_timeout |-> idle_timeout_enable)
    else $error("timeout while disabled");
  a_to_quiet: assert property (bus_timeout |-> quiet_ff >= TIMEOUT_CYCLES - 2)
    else $error("timeout too early");
  a_to_release: assert property (bus_timeout |-> ##[0:1] !sda_oe ##1 !sda_oe)
    else $error("line held after timeout");
  a_oe_on_fall: assert property ($changed(sda_oe) |->
    fall_ff inside {[4'h1:4'h6]} || bus_timeout || $past(bus_timeout))
    else $error("data line moved off clock fall");
  c_clear: cover property (clear_faults);
  c_timeout: cover property (bus_timeout);
  c_ack_high: cover property (sda_oe && scl_in);
endmodule : sscp_port_asserts

bind sscp_port sscp_port_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sscp_port_asserts (
  .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .clear_faults(clear_faults), .bus_timeout(bus_timeout),
  .idle_timeout_enable(idle_timeout_enable));

`default_nettype wire

// ### tb/sscp_master.sv
// Purpose: Behavioural two-wire bus master.
// Assumes: The bench resolves the data wire with a pull-up.
// Notes: A bit takes 125 ns; the clock stands high between frames.
`default_nettype none

module sscp_master
(
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 10ps;
  // A quarter of the bus clock period.
  localparam realtime Q = 31.25;
  // Both lines released: an idle bus.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves only while the clock is low and is read in the middle of the high phase.
  task automatic bit_x(input logic b, output logic r);
    scl = 1'b0;
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q;
  endtask : bit_x
  // Start or repeated start: data falls with the clock high.
  task automatic start();
    logic r;
    bit_x(1'b1, r);
    sda_low = 1'b1;
    #Q;
  endtask : start
  // Stop: data rises with the clock high.
  task automatic stop();
    logic r;
    bit_x(1'b0, r);
    sda_low = 1'b0;
    #Q;
  endtask : stop
  // Eight bits out, most significant first, then the acknowledge back.
  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], r);
    bit_x(1'b1, ack_n);
  endtask : wbyte
  // Eight bits in; released acknowledge on the last byte ends the read.
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, b[i]);
    bit_x(last, r);
  endtask : rbyte
  // Clock held low, data released, until the bench resumes with bit_x.
  task automatic hold_low();
    scl = 1'b0;
    #Q sda_low = 1'b0;
  endtask : hold_low
endmodule : sscp_master

`default_nettype wire

// ### tb/sscp_port_test.sv
// Purpose: Self-checking bench for the serial command port.
// Assumes: The master model owns the clock line.
// Notes: The timeout is cut to TO_CYC cycles to keep stalls short.
`default_nettype none

module sscp_port_test;
  timeunit 1ns;
  timeprecision 10ps;
  import sscp_pkg::*;
  localparam int TO_CYC = 200;
  localparam logic [7:0] AW = {SSCP_OWN_ADDR, 1'b0};
  localparam logic [7:0] AR = {SSCP_OWN_ADDR, 1'b1};
  // Code, byte written and read back, enable left behind.
  typedef struct packed {logic [7:0] code; logic [7:0] data; logic en;} sscp_row_t;
  localparam sscp_row_t ROWS [4] = '{'{8'h10, 8'hA5, 1'b0}, '{SSCP_CFG_ADDR, 8'h08, 1'b1},
    '{8'h7F, 8'h3C, 1'b1}, '{SSCP_CFG_ADDR, 8'hF7, 1'b0}};
  logic clk;
  logic rst_b;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic clear_faults;
  logic bus_timeout;
  logic idle_timeout_enable;
  logic a;
  logic [7:0] v [4];
  int err_count = 0;
  int n_checks = 0;
  int cf_cnt = 0;
  int to_cnt = 0;
  // Either party pulling makes the wire low, else the pull-up wins.
  wire logic sda_w = (sda_low | sda_oe) ? 1'b0 : 1'b1;
  sscp_port #(.TIMEOUT_CYCLES(TO_CYC)) u_sscp_port (.clk(clk), .rst_b(rst_b),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .clear_faults(clear_faults), .bus_timeout(bus_timeout),
    .idle_timeout_enable(idle_timeout_enable));
  sscp_master u_sscp_master (.scl(scl), .sda_low(sda_low), .sda(sda_w));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : check
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // One byte from the master; the port must pull the ninth bit low.
  task automatic send(input logic [7:0] b);
    logic ack_n;
    u_sscp_master.wbyte(b, ack_n);
    check("ack", ack_n, 8'h00);
  endtask : send
  task automatic recv(input logic last, input logic [7:0] exp);
    logic [7:0] got;
    u_sscp_master.rbyte(last, got);
    check("rdata", got, exp);
  endtask : recv
  // Writes n bytes at code, then reads them back after a repeated start.
  task automatic wrrd(input logic [7:0] code, input int n);
    u_sscp_master.start();
    send(AW);
    send(code);
    for (int i = 0; i < n; i++)
      send(v[i]);
    u_sscp_master.stop();
    u_sscp_master.start();
    send(AW);
    send(code);
    u_sscp_master.start();
    send(AR);
    for (int i = 0; i < n; i++)
      recv(i == n - 1, v[i]);
    u_sscp_master.stop();
  endtask : wrrd
  // Address sent, then the clock is held low while the port acknowledges.
  task automatic stall();
    logic r;
    u_sscp_master.start();
    for (int i = 7; i >= 0; i--)
      u_sscp_master.bit_x(AW[i], r);
    u_sscp_master.hold_low();
    repeat (TO_CYC + 40) @(negedge clk);
  endtask : stall
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hang ends the run as a mismatch.
  initial
  begin
    #1ms;
    err_count++;
    report_and_stop();
  end
  // Pulses are counted so that a missing or doubled one shows.
  always @(posedge clk)
  begin
    if (clear_faults === 1'b1)
      cf_cnt++;
    if (bus_timeout === 1'b1)
      to_cnt++;
  end
  initial
  begin
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    check("oe", sda_oe, 8'h00);
    check("out", sda_out, 8'h00);
    check("en", idle_timeout_enable, 8'h00);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    foreach (ROWS[r])
    begin
      v[0] = ROWS[r].data;
      wrrd(ROWS[r].code, 1);
      check("en", idle_timeout_enable, {7'h00, ROWS[r].en});
    end
    check("cf", 8'(cf_cnt), 8'h00);
    u_sscp_master.start();
    u_sscp_master.wbyte(AW ^ 8'h02, a);
    check("nack", a, 8'h01);
    u_sscp_master.stop();
    u_sscp_master.start();
    send(AR);
    recv(1'b1, SSCP_NO_PTR_DATA);
    u_sscp_master.stop();
    u_sscp_master.start();
    send(AW);
    send(8'h55);
    u_sscp_master.stop();
    repeat (10) @(negedge clk);
    check("cf", 8'(cf_cnt), 8'h01);
    v = '{8'h34, 8'h12, 8'h00, 8'h00};
    wrrd(8'h30, 2);
    v = '{8'h03, 8'h11, 8'h22, 8'h33};
    wrrd(8'h40, 4);
    v[0] = 8'h08;
    wrrd(SSCP_CFG_ADDR, 1);
    stall();
    check("to", 8'(to_cnt), 8'h01);
    check("oe", sda_oe, 8'h00);
    u_sscp_master.bit_x(1'b1, a);
    check("idle", a, 8'h01);
    u_sscp_master.stop();
    v[0] = 8'h00;
    wrrd(SSCP_CFG_ADDR, 1);
    stall();
    check("to", 8'(to_cnt), 8'h01);
    check("oe", sda_oe, 8'h01);
    u_sscp_master.bit_x(1'b1, a);
    check("ack", a, 8'h00);
    u_sscp_master.stop();
    v[0] = 8'hFF;
    wrrd(SSCP_CFG_ADDR, 1);
    rst_b = 1'b0;
    @(negedge clk);
    check("en", idle_timeout_enable, 8'h00);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    report_and_stop();
  end
endmodule : sscp_port_test

`default_nettype wire
